// ---- src/rfcsr_defines.svh ----
// Offsets, field positions, reset values and timing counts of the radio control block.
// Assumes inclusion by bare name from the design file.
`ifndef RFCSR_DEFINES_SVH
`define RFCSR_DEFINES_SVH
`define RFCSR_ADDR_MAIN 4'h4
`define RFCSR_ADDR_STATUS 4'h5
`define RFCSR_ADDR_TRIM 4'h6
`define RFCSR_LEN_MAIN 6'd32
`define RFCSR_LEN_STATUS 6'd31
`define RFCSR_LEN_TRIM 6'd6
`define RFCSR_MAIN_RESET 32'h1000_0270
`define RFCSR_TRIM_RESET 6'h20
`define RFCSR_BIT_MVCC 24
`define RFCSR_THR_HI 23
`define RFCSR_THR_LO 18
`define RFCSR_HYS_HI 17
`define RFCSR_HYS_LO 15
`define RFCSR_TXL_HI 14
`define RFCSR_TXL_LO 12
`define RFCSR_BIT_SEL_DISC 11
`define RFCSR_BIT_BW 6
`define RFCSR_BIT_DSREF 4
`define RFCSR_BIT_WUEN 26
`define RFCSR_ADC_PERIOD_NS 12000
`define RFCSR_CLK_PERIOD_NS 4
`define RFCSR_ADC_CYCLES (`RFCSR_ADC_PERIOD_NS / `RFCSR_CLK_PERIOD_NS)
`define RFCSR_ADDR_BITS 4
`endif

// ---- src/rfcsr_pkg.sv ----
// Types of the radio control block.
// Assumes the defines header is on the include path.
package rfcsr_pkg;
  typedef enum logic [2:0] {
    RFCSR_SRC_RSSI = 3'b001,
    RFCSR_SRC_VCC = 3'b010,
    RFCSR_SRC_DISC = 3'b100
  } rfcsr_src_t;
endpackage : rfcsr_pkg

// ---- src/rfcsr_top.sv ----
// Serial register port, level measurement and data gate of the radio control block.
// Assumes an analog front end delivering a single comparator result and a host on three wires.
//
// How it works
// - Status register shows the 6-bit signal-strength code to the host.
// - Converter steps once per 12 us conversion clock, repeatedly.
// - Code moves one step per clock toward the input level.
// - In signal-strength mode, receive data passes only while code exceeds the programmed threshold.
// - Optional hysteresis lowers the release threshold by the programmed amount.
// - Control bits switch the converter to supply or discriminator level.
// - Supply code step is 85 mV against a 1.25 V reference.
// - Main control bit 6 selects discriminator bandwidth, standard by default.
// - Main control bit 4 selects external average or internal DAC slicer reference.
// - Averaging pin released to high impedance during wake-up sleep.
// - Trim bit 1 shifts discriminator level up, bit 0 down.
// - Trim bits 5..2 choose 16 thresholds, reset value 1000.
// - Three-bit power field gives eight levels, 000 lowest, 111 highest.
// - With enable high, serial clock and data are ignored.
// - Host frames each access by enable low then high.
// - One access performs one read or one write on one register.
// - Host port is enable, clock and one two-way data line.
// - Four address bits MSB first, direction bit, then up to 32 data bits.
// - Write bits taken on rising clock; register updates on the fourth rising mclk edge after enable rise.
// - Read data turns around after direction bit, changes on falling edges.
// - Surplus read clocks return zero.
`timescale 1ns/10ps
`include "rfcsr_defines.svh"
module rfcsr_top
  import rfcsr_pkg::*;
#(
  parameter int ADC_CYCLES = `RFCSR_ADC_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic serial_clk,
  input wire logic serial_frame_enable_n,
  input wire logic serial_io_line_in,
  output logic serial_io_line_out,
  output logic serial_io_line_oe,
  input wire logic level_above_in,
  input wire logic demod_data_in,
  input wire logic sleep_phase,
  output logic rx_data_out,
  output logic [2:0] adc_source_sel,
  output logic disc_bw_wide,
  output logic slicer_ref_internal,
  output logic slicer_average_pin_hiz,
  output logic disc_shift_up,
  output logic disc_shift_down,
  output logic [3:0] slicer_dac_code,
  output logic [2:0] tx_power_level,
  output logic [5:0] adc_code
);
  // Tick counter needs at least two states
  if (ADC_CYCLES < 2) begin : gen_bad_adc_cycles
    $error("ADC_CYCLES too small");
  end

  ////////////////////////////////////////////////////////////////
  // Link domain: shifter on serial_clk; frame flag and read side reset while frame is idle
  logic frame_rst_n;
  logic [5:0] bit_cnt;
  logic [3:0] addr_sh;
  logic dir_write;
  logic [31:0] data_sh;
  logic [5:0] data_cnt;
  logic [31:0] rd_snap;
  logic [5:0] rd_len;
  logic rd_active;
  logic [5:0] rd_idx;
  logic frame_open;
  logic frame_tog;
  assign frame_rst_n = rstn & ~serial_frame_enable_n;
  wire in_addr = (bit_cnt < 6'd4);
  wire at_dir = (bit_cnt == 6'd4);
  // Main and trim values seen here are quasi-static while the host talks
  logic [31:0] main_control_reg;
  logic [5:0] slicer_threshold_trim;
  logic [5:0] code_stat;
  wire [3:0] addr_full = {addr_sh[2:0], serial_io_line_in};
  wire addr_main = (addr_sh == `RFCSR_ADDR_MAIN);
  wire addr_stat = (addr_sh == `RFCSR_ADDR_STATUS);
  wire addr_trim = (addr_sh == `RFCSR_ADDR_TRIM);
  wire [31:0] rd_word = addr_main ? main_control_reg :
                        addr_stat ? {1'b0, code_stat, 25'h0} :
                        addr_trim ? {slicer_threshold_trim, 26'h0} : 32'hFFFF_FFFF;
  wire [5:0] rd_word_len = addr_main ? `RFCSR_LEN_MAIN :
                           addr_stat ? `RFCSR_LEN_STATUS :
                           addr_trim ? `RFCSR_LEN_TRIM : 6'd32;
  // First edge of a frame; cleared while enable is high
  always_ff @(posedge serial_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      frame_open <= 1'b0;
    end else begin
      frame_open <= 1'b1;
    end
  end
  // Fields survive enable rise so the commit side can still read them
  always_ff @(posedge serial_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt <= 6'h0;
      addr_sh <= 4'h0;
      dir_write <= 1'b0;
      data_sh <= 32'h0000_0000;
      data_cnt <= 6'h0;
      rd_snap <= 32'h0000_0000;
      rd_len <= 6'h0;
      frame_tog <= 1'b0;
    end else if (!serial_frame_enable_n) begin
      if (!frame_open) begin
        addr_sh <= {3'b000, serial_io_line_in};
        bit_cnt <= 6'd1;
        dir_write <= 1'b0;
        data_sh <= 32'h0000_0000;
        data_cnt <= 6'h0;
        frame_tog <= ~frame_tog;
      end else if (in_addr) begin
        addr_sh <= addr_full;
        bit_cnt <= bit_cnt + 6'd1;
      end else if (at_dir) begin
        dir_write <= serial_io_line_in;
        rd_snap <= rd_word;
        rd_len <= rd_word_len;
        bit_cnt <= bit_cnt + 6'd1;
      end else if (dir_write && data_cnt < 6'd32) begin
        data_sh <= {data_sh[30:0], serial_io_line_in};
        data_cnt <= data_cnt + 6'd1;
      end
    end
  end
  // Read side: drive from falling edge after the direction bit
  always_ff @(negedge serial_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rd_active <= 1'b0;
      rd_idx <= 6'h0;
      serial_io_line_out <= 1'b0;
    end else if (bit_cnt == 6'd5 && !dir_write) begin
      rd_active <= 1'b1;
      if (rd_idx < rd_len) begin
        serial_io_line_out <= rd_snap[5'(6'd31 - rd_idx)];
        rd_idx <= rd_idx + 6'd1;
      end else begin
        serial_io_line_out <= 1'b0;
      end
    end
  end
  assign serial_io_line_oe = rd_active;

  ////////////////////////////////////////////////////////////////
  // Commit: frame end is a level, crossed into mclk with two flops
  logic [2:0] fe_sync;
  logic [3:0] cap_addr;
  logic cap_write;
  logic [31:0] cap_data;
  logic [5:0] cap_cnt;
  logic seen_tog;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fe_sync <= 3'b111;
    end else begin
      fe_sync <= {fe_sync[1:0], serial_frame_enable_n};
    end
  end
  // Link fields are stable once the frame has ended; sampled after the sync
  wire frame_end = fe_sync[1] & ~fe_sync[2];
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cap_addr <= 4'h0;
      cap_write <= 1'b0;
      cap_data <= 32'h0000_0000;
      cap_cnt <= 6'h0;
      seen_tog <= 1'b0;
    end else begin
      // Toggle check keeps a clockless frame from replaying the last write
      cap_write <= frame_end & dir_write & (bit_cnt == 6'd5) & (frame_tog != seen_tog);
      seen_tog <= frame_end ? frame_tog : seen_tog;
      cap_addr <= addr_sh;
      cap_data <= data_sh;
      cap_cnt <= data_cnt;
    end
  end
  // Partial writes keep low bits: align MSB-first bits under a mask
  wire [5:0] wlen = (cap_addr == `RFCSR_ADDR_TRIM) ? `RFCSR_LEN_TRIM : `RFCSR_LEN_MAIN;
  wire [5:0] nbits = (cap_cnt > wlen) ? wlen : cap_cnt;
  wire [5:0] nskip = (cap_cnt > wlen) ? 6'(cap_cnt - wlen) : 6'h0;
  wire [31:0] wd_top = (cap_data >> nskip) << (6'd32 - nbits);
  wire [31:0] wmask = (nbits == 6'd0) ? 32'h0 : ~(32'hFFFF_FFFF >> nbits);
  wire [31:0] next_main = (main_control_reg & ~wmask) | (wd_top & wmask);
  wire [31:0] trim_wide = {slicer_threshold_trim, 26'h0};
  wire [31:0] next_trim_w = (trim_wide & ~wmask) | (wd_top & wmask);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      main_control_reg <= `RFCSR_MAIN_RESET;
      slicer_threshold_trim <= `RFCSR_TRIM_RESET;
    end else if (cap_write) begin
      if (cap_addr == `RFCSR_ADDR_MAIN) begin
        main_control_reg <= next_main;
      end
      if (cap_addr == `RFCSR_ADDR_TRIM) begin
        slicer_threshold_trim <= next_trim_w[31:26];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Converter: 12 us tick, one code step per tick
  logic [$clog2(ADC_CYCLES)-1:0] tick_cnt;
  logic [1:0] cmp_sync;
  logic [1:0] dem_sync;
  logic gate_open;
  wire tick = (tick_cnt == ($clog2(ADC_CYCLES))'(ADC_CYCLES - 1));
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmp_sync <= 2'b00;
      dem_sync <= 2'b00;
      tick_cnt <= '0;
    end else begin
      cmp_sync <= {cmp_sync[0], level_above_in};
      dem_sync <= {dem_sync[0], demod_data_in};
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
    end
  end
  // Tracking converter trades speed for a single comparator
  wire [5:0] next_code = cmp_sync[1] ? ((adc_code == 6'h3F) ? adc_code : adc_code + 6'd1) :
                         ((adc_code == 6'h00) ? adc_code : adc_code - 6'd1);
  wire [5:0] thr = main_control_reg[`RFCSR_THR_HI:`RFCSR_THR_LO];
  wire [5:0] hys = {3'b000, main_control_reg[`RFCSR_HYS_HI:`RFCSR_HYS_LO]};
  wire [5:0] thr_rel = (thr > hys) ? 6'(thr - hys) : 6'h0;
  wire src_rssi = (adc_source_sel == RFCSR_SRC_RSSI);
  wire next_gate = gate_open ? (next_code > thr_rel) : (next_code > thr);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      adc_code <= 6'h00;
      code_stat <= 6'h00;
      gate_open <= 1'b0;
    end else if (tick) begin
      adc_code <= next_code;
      if (src_rssi) begin
        code_stat <= next_code;
        gate_open <= next_gate;
      end
    end
  end
  assign rx_data_out = gate_open & dem_sync[1];
  // Supply measurement weight: 85 mV per step over a 1.25 V reference, analog side
  assign adc_source_sel = main_control_reg[`RFCSR_BIT_MVCC] ? RFCSR_SRC_VCC :
                          main_control_reg[`RFCSR_BIT_SEL_DISC] ? RFCSR_SRC_DISC : RFCSR_SRC_RSSI;

  ////////////////////////////////////////////////////////////////
  // Analog setting decode
  logic [1:0] slp_sync;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      slp_sync <= 2'b00;
    end else begin
      slp_sync <= {slp_sync[0], sleep_phase};
    end
  end
  assign disc_bw_wide = ~main_control_reg[`RFCSR_BIT_BW];
  assign slicer_ref_internal = ~main_control_reg[`RFCSR_BIT_DSREF];
  assign slicer_average_pin_hiz = slp_sync[1] & main_control_reg[`RFCSR_BIT_WUEN];
  assign disc_shift_up = slicer_threshold_trim[1];
  assign disc_shift_down = slicer_threshold_trim[0];
  assign slicer_dac_code = slicer_threshold_trim[5:2];
  assign tx_power_level = main_control_reg[`RFCSR_TXL_HI:`RFCSR_TXL_LO];
endmodule : rfcsr_top

// ---- tb/rfcsr_host_model.sv ----
// Host model: three-wire serial master for the radio control block.
// Assumes the bench resolves the shared data line from the block's output enable.
`timescale 1ns/10ps
module rfcsr_host_model (
  output logic serial_clk,
  output logic serial_frame_enable_n,
  output logic host_data,
  input wire logic serial_io_line_in
);
  initial begin
    serial_clk = 1'b0;
    serial_frame_enable_n = 1'b1;
    host_data = 1'b0;
  end
  // Clock stands low between frames; 64 ns serial period
  task automatic xfer(input logic [3:0] a, input logic wr, input int n, input logic [31:0] d,
                      output logic [31:0] q);
    logic [36:0] s;
    s = {a, wr, d};
    q = '0;
    #3.3 serial_frame_enable_n = 1'b0;
    for (int i = 0; i < 5 + n; i++) begin
      // Released line toggles so a stale level never reads as data
      host_data = (i < 5 || wr) ? s[36-i] : ~host_data;
      #32 serial_clk = 1'b1;
      if (i > 4) q = {q[30:0], serial_io_line_in};
      #32 serial_clk = 1'b0;
    end
    #21 serial_frame_enable_n = 1'b1;
    #60;
  endtask : xfer
endmodule : rfcsr_host_model

// ---- tb/rfcsr_top_assertions.sv ----
// Port checker of the radio control block.
// Assumes binding onto rfcsr_top, all checks sampled on mclk.
`timescale 1ns/10ps
module rfcsr_top_assertions #(
  parameter int ADC_CYCLES = 8
) (
  input wire logic mclk, rstn, serial_frame_enable_n, serial_io_line_oe,
  input wire logic demod_data_in, sleep_phase, rx_data_out, disc_bw_wide,
  input wire logic slicer_ref_internal, slicer_average_pin_hiz,
  input wire logic [2:0] adc_source_sel, tx_power_level,
  input wire logic [3:0] slicer_dac_code,
  input wire logic [5:0] adc_code
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence frame_idle; serial_frame_enable_n [*8]; endsequence
  sequence code_holds; $stable(adc_code) [*6]; endsequence
  AST_IDLE_NO_DRIVE: assert property (serial_frame_enable_n [*3] |-> !serial_io_line_oe)
    else $error("data line driven outside a frame");
  AST_REG_STABLE_IDLE: assert property (frame_idle |-> $stable(tx_power_level) && $stable(slicer_dac_code))
    else $error("settings changed with no frame");
  AST_RESET_DECODE: assert property ($rose(rstn) |-> slicer_dac_code == 4'h8 && !disc_bw_wide
    && !slicer_ref_internal && tx_power_level == 3'h0 && adc_source_sel == 3'h1)
    else $error("decoded settings wrong after reset");
  AST_SRC_ONEHOT: assert property ($onehot(adc_source_sel))
    else $error("converter source not one-hot");
  AST_CODE_STEP: assert property ($changed(adc_code) |->
    adc_code == $past(adc_code) + 6'h1 || adc_code == $past(adc_code) - 6'h1)
    else $error("code moved more than one step");
  AST_CODE_PACE: assert property ($changed(adc_code) |=> code_holds)
    else $error("code stepped faster than the conversion clock");
  AST_GATE_FOLLOWS: assert property (rx_data_out |-> $past(demod_data_in, 2))
    else $error("gated data not from demodulated data");
  AST_HIZ_SLEEP: assert property ((!sleep_phase) [*4] |-> !slicer_average_pin_hiz)
    else $error("averaging pin released outside sleep");
endmodule : rfcsr_top_assertions
bind rfcsr_top rfcsr_top_assertions #(.ADC_CYCLES(ADC_CYCLES)) rfcsr_top_assertions_inst (.mclk, .rstn,
  .serial_frame_enable_n, .serial_io_line_oe, .demod_data_in, .sleep_phase, .rx_data_out, .disc_bw_wide,
  .slicer_ref_internal, .slicer_average_pin_hiz, .adc_source_sel, .tx_power_level, .slicer_dac_code, .adc_code);

// ---- tb/rfcsr_top_bench.sv ----
// Self-checking bench of the radio control block with a serial host model.
// Assumes the host model and checker are compiled first.
`timescale 1ns/10ps
module rfcsr_top_bench;
  import rfcsr_pkg::*;
  logic mclk, rstn, level_above_in, demod_data_in, sleep_phase, serial_clk, serial_frame_enable_n, host_data;
  logic serial_io_line_out, serial_io_line_oe, rx_data_out, disc_bw_wide, slicer_ref_internal;
  logic slicer_average_pin_hiz, disc_shift_up, disc_shift_down;
  logic [2:0] adc_source_sel, tx_power_level;
  logic [3:0] slicer_dac_code;
  logic [5:0] adc_code;
  logic [31:0] q, d, seed;
  int bad_count, n_tests;
  wire serial_io_line_in = serial_io_line_oe ? serial_io_line_out : host_data;
  rfcsr_top #(.ADC_CYCLES(8)) rfcsr_top_inst (.mclk, .rstn, .serial_clk, .serial_frame_enable_n,
    .serial_io_line_in, .serial_io_line_out, .serial_io_line_oe, .level_above_in, .demod_data_in,
    .sleep_phase, .rx_data_out, .adc_source_sel, .disc_bw_wide, .slicer_ref_internal, .slicer_average_pin_hiz,
    .disc_shift_up, .disc_shift_down, .slicer_dac_code, .tx_power_level, .adc_code);
  rfcsr_host_model rfcsr_host_model_inst (.serial_clk, .serial_frame_enable_n, .host_data, .serial_io_line_in);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  // Supply select outranks discriminator select
  function automatic logic [2:0] exp_src(input logic [31:0] m);
    return m[24] ? RFCSR_SRC_VCC : m[11] ? RFCSR_SRC_DISC : RFCSR_SRC_RSSI;
  endfunction : exp_src
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {rstn, level_above_in, demod_data_in, sleep_phase} = 4'h0;
    seed = 32'h0000_355c;
    repeat (12) @(negedge mclk);
    rstn = 1'b1;
    rfcsr_host_model_inst.xfer(4'h4, 1'b0, 32, '0, q);
    check(q, 32'h1000_0270);
    rfcsr_host_model_inst.xfer(4'h6, 1'b0, 8, '0, q);
    check(q, 32'h0000_0080);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      d = {seed[31:27], 1'b0, seed[25], i == 5, seed[23:15], i[2:0], i == 6, seed[10:0]};
      rfcsr_host_model_inst.xfer(4'h4, 1'b1, 32, d, q);
      rfcsr_host_model_inst.xfer(4'h4, 1'b0, 32, '0, q);
      check(q, d);
      check({tx_power_level, disc_bw_wide, slicer_ref_internal, adc_source_sel}, {d[14:12], ~d[6], ~d[4], exp_src(d)});
    end
    check(slicer_dac_code, 4'h8);
    rfcsr_host_model_inst.xfer(4'h6, 1'b1, 6, 32'hd400_0000, q);
    check({slicer_dac_code, disc_shift_up, disc_shift_down}, 6'h35);
    rfcsr_host_model_inst.xfer(4'h6, 1'b1, 2, 32'h0000_0000, q);
    check({slicer_dac_code, disc_shift_up, disc_shift_down}, 6'h05);
    rfcsr_host_model_inst.xfer(4'h6, 1'b1, 10, 32'hffc0_0000, q);
    check({slicer_dac_code, disc_shift_up, disc_shift_down}, 6'h3f);
    rfcsr_host_model_inst.xfer(4'hc, 1'b0, 34, '0, q);
    check(q, 32'hffff_fffc);
    rfcsr_host_model_inst.xfer(4'h4, 1'b1, 32, 32'h0428_0000, q);
    @(negedge mclk);
    {level_above_in, demod_data_in, sleep_phase} = 3'h7;
    repeat (600) @(negedge mclk);
    check({adc_code, rx_data_out, slicer_average_pin_hiz}, {6'h3f, 2'b11});
    rfcsr_host_model_inst.xfer(4'h5, 1'b0, 7, '0, q);
    check(q, 32'h0000_003f);
    @(negedge mclk);
    level_above_in = 1'b0;
    repeat (384) @(negedge mclk);
    check(rx_data_out, 1'b1);
    repeat (64) @(negedge mclk);
    check(rx_data_out, 1'b0);
    repeat (600) @(negedge mclk);
    check(adc_code, 6'h00);
    tally_and_finish();
  end
endmodule : rfcsr_top_bench
